//--- core/lmc_ctrl.sv
/*
 * lcd mode and clock control: decodes mode-settings and clock-setup command
 * bytes, runs the internal oscillator enable, picks the timing source,
 * drives the clock pin and gives the waveform logic its drive mode.
 * assumes command bytes arrive already framed by the serial interface,
 * one-cycle cmd_valid, and the clock pin is an unsynchronised raw level.
 */
`timescale 1ns/1ns
`include "lmc_defines.svh"

module lmc_ctrl (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// command bytes from the serial interface
	input wire logic [7:0] cmd_byte,
	input wire logic cmd_valid,
	// frame prescaler divide factor q from the frame-frequency setting
	input wire logic [6:0] divide_q,
	// clock pin, three signals; oe low drives
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe_n,
	// towards waveform generation
	output logic timing_tick,
	output logic frame_phase,
	output logic outputs_grounded,
	output lmc_pkg::lmc_drive_t drive_mode,
	output logic osc_running,
	// settings readback
	output lmc_pkg::lmc_mode_t mode_state,
	output lmc_pkg::lmc_clk_t clk_state
);

	lmc_pkg::lmc_mode_t mode_r, mode_nxt;
	lmc_pkg::lmc_clk_t clk_r, clk_nxt;
	logic [`LMC_OSC_W-1:0] osc_cnt_r, osc_cnt_nxt;
	logic [`LMC_Q_W-1:0] q_cnt_r, q_cnt_nxt;
	logic [`LMC_FRAME_W-1:0] fr_cnt_r, fr_cnt_nxt;
	logic frame_phase_r, frame_phase_nxt;
	logic pin_meta_r, pin_sync_r, pin_prev_r;
	logic clk_out_r, clk_out_nxt;
	logic osc_tick, int_tick, ext_tick, sel_tick;
	logic is_clk_cmd, is_mode_cmd;

	function automatic logic [6:0] half_q(input logic [6:0] q);
		half_q = {1'b0, q[6:1]};
	endfunction : half_q

	assign is_clk_cmd = cmd_valid && (cmd_byte[7:3] == `LMC_CLK_CMD_CODE);
	assign is_mode_cmd = cmd_valid && (cmd_byte[7:4] == `LMC_MODE_CMD_CODE);

	// settings
	always_comb begin
		mode_nxt = mode_r;
		clk_nxt = clk_r;
		if (is_mode_cmd) begin
			mode_nxt.inversion_select = cmd_byte[`LMC_BIT_INV];
			mode_nxt.power_down_bit = cmd_byte[`LMC_BIT_PD];
			mode_nxt.display_on = cmd_byte[`LMC_BIT_DISP];
		end
		if (is_clk_cmd) begin
			// all three fields land in one cycle
			clk_nxt.ext_rate_select = cmd_byte[`LMC_BIT_RATE];
			clk_nxt.clock_out_drive = cmd_byte[`LMC_BIT_COE];
			clk_nxt.ext_source = cmd_byte[`LMC_BIT_SRC];
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_r <= '{`LMC_RST_INV, `LMC_RST_PD, `LMC_RST_DISP};
			clk_r <= '{`LMC_RST_RATE, `LMC_RST_COE, `LMC_RST_SRC};
		end else begin
			mode_r <= mode_nxt;
			clk_r <= clk_nxt;
		end
	end

	// clock pin synchroniser and edge detect
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			pin_prev_r <= 1'b0;
		end else begin
			pin_meta_r <= clock_pin_in;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	assign osc_running = !clk_r.ext_source && !mode_r.power_down_bit;
	assign osc_tick = osc_running && (osc_cnt_r == `LMC_ONE_OSC);
	assign ext_tick = clk_r.ext_source && pin_sync_r && !pin_prev_r;
	// rate select only matters for the external source; at 9.6k the pin is
	// already the intermediate rate, at 230k it goes through the q prescaler
	assign int_tick = (clk_r.ext_source && !clk_r.ext_rate_select) ? ext_tick
		: ((clk_r.ext_source ? ext_tick : osc_tick) && q_cnt_r == `LMC_ONE_Q);
	// with the external source, no pin edges means no ticks; settings stay untouched
	assign sel_tick = int_tick;

	// oscillator, prescaler and frame timing
	always_comb begin
		osc_cnt_nxt = osc_cnt_r;
		q_cnt_nxt = q_cnt_r;
		fr_cnt_nxt = fr_cnt_r;
		frame_phase_nxt = frame_phase_r;
		clk_out_nxt = clk_out_r;
		if (!osc_running) begin
			osc_cnt_nxt = `LMC_OSC_W'(`LMC_OSC_DIV);
		end else if (osc_tick) begin
			osc_cnt_nxt = `LMC_OSC_W'(`LMC_OSC_DIV);
		end else begin
			osc_cnt_nxt = osc_cnt_r - `LMC_ONE_OSC;
		end
		if ((clk_r.ext_source ? ext_tick : osc_tick)) begin
			if (q_cnt_r <= `LMC_ONE_Q) begin
				q_cnt_nxt = divide_q;
			end else begin
				q_cnt_nxt = q_cnt_r - `LMC_ONE_Q;
			end
			// high for the lower half of q: duty tracks the ratio
			clk_out_nxt = (q_cnt_nxt <= half_q(divide_q));
		end
		if (sel_tick) begin
			if (fr_cnt_r == `LMC_FRAME_TICKS) begin
				fr_cnt_nxt = `LMC_ZERO_FR;
				frame_phase_nxt = !frame_phase_r;
			end else begin
				fr_cnt_nxt = fr_cnt_r + `LMC_FRAME_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_cnt_r <= `LMC_ONE_OSC;
			q_cnt_r <= `LMC_ONE_Q;
			fr_cnt_r <= `LMC_ZERO_FR;
			frame_phase_r <= 1'b0;
			clk_out_r <= 1'b0;
		end else begin
			osc_cnt_r <= osc_cnt_nxt;
			q_cnt_r <= q_cnt_nxt;
			fr_cnt_r <= fr_cnt_nxt;
			frame_phase_r <= frame_phase_nxt;
			clk_out_r <= clk_out_nxt;
		end
	end

	// pin drive: in power-down with output enabled and the internal source the pin sits high
	always_comb begin
		clock_pin_oe_n = 1'b1;
		clock_pin_out = 1'b0;
		if (!clk_r.ext_source && clk_r.clock_out_drive) begin
			clock_pin_oe_n = 1'b0;
			clock_pin_out = mode_r.power_down_bit ? 1'b1 : clk_out_r;
		end
	end

	// power-down wins over display on; display change acts at once
	assign outputs_grounded = mode_r.power_down_bit || !mode_r.display_on;
	always_comb begin
		if (outputs_grounded) begin
			drive_mode = lmc_pkg::LMC_DRV_GROUND;
		end else if (mode_r.inversion_select) begin
			drive_mode = lmc_pkg::LMC_DRV_FRAME_INV;
		end else begin
			drive_mode = lmc_pkg::LMC_DRV_LINE_INV;
		end
	end

	assign timing_tick = sel_tick && !mode_r.power_down_bit;
	assign frame_phase = frame_phase_r;
	assign mode_state = mode_r;
	assign clk_state = clk_r;

	// checks
	a_ground_out: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(mode_r.power_down_bit || !mode_r.display_on) |-> drive_mode == lmc_pkg::LMC_DRV_GROUND)
		else $error("lcd outputs not grounded");

	a_disp_ground: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!mode_r.display_on |-> outputs_grounded)
		else $error("display off but outputs live");

	a_tick_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mode_r.power_down_bit |-> !timing_tick)
		else $error("timing tick in power-down");

	a_disp_now: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(is_mode_cmd && !cmd_byte[`LMC_BIT_DISP]) |=> outputs_grounded)
		else $error("display off not immediate");

	a_disp_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(is_mode_cmd && cmd_byte[`LMC_BIT_DISP] && !cmd_byte[`LMC_BIT_PD]) |=> !outputs_grounded)
		else $error("display on not immediate");

	a_mode_load: assert property (@(posedge sys_clk) disable iff (!arst_n)
		is_mode_cmd |=> (mode_r == $past(cmd_byte[2:0])))
		else $error("mode settings not loaded");

	a_clk_cmd_upd: assert property (@(posedge sys_clk) disable iff (!arst_n)
		is_clk_cmd |=> (clk_r == $past(cmd_byte[2:0])))
		else $error("clock setup not loaded");

	a_cmd_refused: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(cmd_valid && !is_mode_cmd && !is_clk_cmd) |=> ($stable(mode_r) && $stable(clk_r)))
		else $error("unknown byte changed settings");

	a_settings_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!cmd_valid |=> ($stable(mode_r) && $stable(clk_r)))
		else $error("settings changed without command");

	a_pin_tristate: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!clk_r.clock_out_drive || clk_r.ext_source) |-> clock_pin_oe_n)
		else $error("clock pin driven while disabled");

	a_pin_pd_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!clk_r.ext_source && clk_r.clock_out_drive && mode_r.power_down_bit)
			|-> (!clock_pin_oe_n && clock_pin_out))
		else $error("clock pin not high in power-down");

	a_pin_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!clk_r.ext_source && clk_r.clock_out_drive && !mode_r.power_down_bit)
			|-> (!clock_pin_oe_n && clock_pin_out == clk_out_r))
		else $error("clock pin not showing prescaled clock");

	a_duty_ratio: assert property (@(posedge sys_clk) disable iff (!arst_n)
		osc_tick |=> (clk_out_r == (q_cnt_r <= half_q(divide_q))))
		else $error("clock out level off the divide ratio");

	a_osc_stop: assert property (@(posedge sys_clk) disable iff (!arst_n)
		mode_r.power_down_bit |=> (!osc_tick && osc_cnt_r == `LMC_OSC_W'(`LMC_OSC_DIV)))
		else $error("oscillator ticking in power-down");

	a_osc_period: assert property (@(posedge sys_clk) disable iff (!arst_n)
		osc_tick |=> (osc_cnt_r == `LMC_OSC_W'(`LMC_OSC_DIV)))
		else $error("oscillator period not reloaded");

	a_ext_src: assert property (@(posedge sys_clk) disable iff (!arst_n)
		clk_r.ext_source |-> !osc_running)
		else $error("osc runs with external source");

	a_rate_ignore: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!clk_r.ext_source |-> (sel_tick == (osc_tick && q_cnt_r == `LMC_ONE_Q)))
		else $error("rate select used with internal osc");

	a_ext_direct: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_r.ext_source && !clk_r.ext_rate_select) |-> (sel_tick == ext_tick))
		else $error("slow external clock not used directly");

	a_ext_prescale: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_r.ext_source && clk_r.ext_rate_select)
			|-> (sel_tick == (ext_tick && q_cnt_r == `LMC_ONE_Q)))
		else $error("fast external clock not prescaled");

	a_ext_stall: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(clk_r.ext_source && !ext_tick) |-> !sel_tick)
		else $error("timing moved without pin edge");

	a_frame_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!sel_tick |=> ($stable(fr_cnt_r) && $stable(frame_phase_r)))
		else $error("frame timing moved without a tick");

	a_inv_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!outputs_grounded && mode_r.inversion_select) |-> drive_mode == lmc_pkg::LMC_DRV_FRAME_INV)
		else $error("frame inversion not selected");

	a_line_inv: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(!outputs_grounded && !mode_r.inversion_select) |-> drive_mode == lmc_pkg::LMC_DRV_LINE_INV)
		else $error("line inversion not selected");

	a_frame_flip: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(sel_tick && fr_cnt_r == `LMC_FRAME_TICKS) |=> frame_phase_r != $past(frame_phase_r))
		else $error("frame phase did not alternate");

	c_pd_entry: cover property (@(posedge sys_clk) disable iff (!arst_n)
		!mode_r.display_on ##1 mode_r.power_down_bit);
	c_clk_out: cover property (@(posedge sys_clk) disable iff (!arst_n)
		!clock_pin_oe_n && clock_pin_out);
	c_ext_tick: cover property (@(posedge sys_clk) disable iff (!arst_n)
		clk_r.ext_source && sel_tick);
	c_frame_wrap: cover property (@(posedge sys_clk) disable iff (!arst_n)
		sel_tick && fr_cnt_r == `LMC_FRAME_TICKS);
	c_line_mode: cover property (@(posedge sys_clk) disable iff (!arst_n)
		drive_mode == lmc_pkg::LMC_DRV_LINE_INV);

endmodule : lmc_ctrl

//--- core/lmc_defines.svh
/*
 * constants for the lcd mode and clock control block: command codes,
 * field positions, reset values and clock rate figures.
 * assumes the 50 MHz sys_clk of the block file.
 */
`ifndef LMC_DEFINES_SVH
`define LMC_DEFINES_SVH

// clock-setup command: upper five bits fixed
`define LMC_CLK_CMD_CODE 5'h03
// mode-settings command: upper four bits fixed
`define LMC_MODE_CMD_CODE 4'h5
`define LMC_BIT_RATE 2
`define LMC_BIT_COE 1
`define LMC_BIT_SRC 0
`define LMC_BIT_INV 2
`define LMC_BIT_PD 1
`define LMC_BIT_DISP 0

// defaults: line inversion, power-up, display off, internal osc, pin off
`define LMC_RST_INV 1'b0
`define LMC_RST_PD 1'b0
`define LMC_RST_DISP 1'b0
`define LMC_RST_RATE 1'b0
`define LMC_RST_COE 1'b0
`define LMC_RST_SRC 1'b0

// internal oscillator modelled as an enable from sys_clk
`define LMC_SYS_HZ 50000000
`define LMC_OSC_HZ 230000
`define LMC_OSC_DIV ((`LMC_SYS_HZ + `LMC_OSC_HZ - 1) / `LMC_OSC_HZ)
`define LMC_OSC_W 8
// intermediate clock: osc / q, q from the frame prescaler input
`define LMC_Q_W 7
// frame = 48 intermediate ticks; one line slot per tick group
`define LMC_FRAME_TICKS 6'h2f
`define LMC_FRAME_W 6
`define LMC_ONE_OSC 8'h01
`define LMC_ONE_Q 7'h01
`define LMC_ZERO_FR 6'h00

`endif

//--- core/lmc_pkg.sv
/*
 * types for the lcd mode and clock control block.
 * assumes lmc_defines.svh is compiled alongside.
 */
package lmc_pkg;

	typedef struct packed {
		logic inversion_select;
		logic power_down_bit;
		logic display_on;
	} lmc_mode_t;

	typedef struct packed {
		logic ext_rate_select;
		logic clock_out_drive;
		logic ext_source;
	} lmc_clk_t;

	typedef enum logic [1:0] {
		LMC_DRV_GROUND,
		LMC_DRV_LINE_INV,
		LMC_DRV_FRAME_INV
	} lmc_drive_t;

endpackage : lmc_pkg

//--- verification/lmc_host.sv
/* host model: sends command bytes and clocks the shared pin.
   assumes tb resolves the pin from the block's output enable. */
`timescale 1ns/1ns
module lmc_host (
	// clock
	input wire logic sys_clk,
	// command side
	output logic [7:0] cmd_byte,
	output logic cmd_valid,
	// external clock, stands still between bursts
	output logic ext_clk
);
	initial begin
		cmd_byte = 8'h00;
		cmd_valid = 1'b0;
		ext_clk = 1'b0;
	end
	// one setting change per call, never a flashing loop
	task send(input logic [7:0] b);
		@(posedge sys_clk);
		#1 cmd_byte = b;
		cmd_valid = 1'b1;
		@(posedge sys_clk);
		#1 cmd_valid = 1'b0;
		// released bus shows the inverse, not a stale byte
		cmd_byte = ~b;
	endtask : send
	// n rising edges, then the clock stops low
	task burst(input int half, input int n);
		repeat (n) begin
			#half ext_clk = 1'b1;
			#half ext_clk = 1'b0;
		end
	endtask : burst
endmodule : lmc_host

//--- verification/tb.sv
/* testbench for lmc_ctrl: reset, mode, clock source and power-down.
   assumes lmc_pkg compiled first and the host model beside it. */
`timescale 1ns/1ns
module tb;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] q = 7'h02;
	logic [7:0] cmd_byte;
	logic cmd_valid, ext_clk, pin_out, pin_oe_n, tick, fph, gnd, osc;
	lmc_pkg::lmc_drive_t drv;
	lmc_pkg::lmc_mode_t ms;
	lmc_pkg::lmc_clk_t cs;
	// block drives when oe_n is low, else the host clock reaches the pin
	wire logic pin = pin_oe_n ? ext_clk : pin_out;
	int fails = 0;
	int comparisons = 0;
	int ticks = 0;
	int highs = 0;
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (tick === 1'b1) begin
			ticks++;
		end
		if (pin_oe_n === 1'b0 && pin_out === 1'b1) begin
			highs++;
		end
	end
	lmc_host i_host (.sys_clk(sys_clk), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid), .ext_clk(ext_clk));
	lmc_ctrl i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid), .divide_q(q), .clock_pin_in(pin),
		.clock_pin_out(pin_out), .clock_pin_oe_n(pin_oe_n),
		.timing_tick(tick), .frame_phase(fph), .outputs_grounded(gnd),
		.drive_mode(drv), .osc_running(osc), .mode_state(ms), .clk_state(cs));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task look(input logic [5:0] e_set, input logic [2:0] e_fl,
		input lmc_pkg::lmc_drive_t e_drv);
		chk({2'h0, ms, cs}, {2'h0, e_set});
		chk({3'h0, pin_oe_n, gnd, osc, drv}, {3'h0, e_fl, e_drv});
	endtask : look
	task st(input logic [7:0] b, input logic [5:0] e_set,
		input logic [2:0] e_fl, input lmc_pkg::lmc_drive_t e_drv);
		i_host.send(b);
		look(e_set, e_fl, e_drv);
	endtask : st
	task idle(input int n);
		ticks = 0;
		highs = 0;
		repeat (n) @(posedge sys_clk);
	endtask : idle
	task t_mode;
		look(6'h00, 3'h7, lmc_pkg::LMC_DRV_GROUND);
		st(8'h51, 6'h08, 3'h5, lmc_pkg::LMC_DRV_LINE_INV);
		st(8'h55, 6'h28, 3'h5, lmc_pkg::LMC_DRV_FRAME_INV);
		st(8'h40, 6'h28, 3'h5, lmc_pkg::LMC_DRV_FRAME_INV);
		$display("t_mode done");
	endtask : t_mode
	task t_clk;
		st(8'h1a, 6'h2a, 3'h1, lmc_pkg::LMC_DRV_FRAME_INV);
		idle(4360);
		chk(8'(ticks >= 9 && ticks <= 11), 8'h01);
		chk(8'(highs >= 2000 && highs <= 2400), 8'h01);
		st(8'h1f, 6'h2f, 3'h4, lmc_pkg::LMC_DRV_FRAME_INV);
		ticks = 0;
		i_host.burst(2170, 8);
		repeat (10) @(posedge sys_clk);
		chk(8'(ticks), 8'h04);
		st(8'h19, 6'h29, 3'h4, lmc_pkg::LMC_DRV_FRAME_INV);
		ticks = 0;
		i_host.burst(52000, 4);
		repeat (10) @(posedge sys_clk);
		chk(8'(ticks), 8'h04);
		$display("t_clk done");
	endtask : t_clk
	// slow external source: 48 pin edges make exactly one frame wrap
	task t_frame;
		logic ph;
		ph = fph;
		ticks = 0;
		i_host.burst(210, 48);
		repeat (10) @(posedge sys_clk);
		chk(8'(ticks), 8'h30);
		chk(8'(fph ^ ph), 8'h01);
		$display("t_frame done");
	endtask : t_frame
	task t_stall;
		st(8'h54, 6'h21, 3'h6, lmc_pkg::LMC_DRV_GROUND);
		idle(2000);
		chk(8'(ticks), 8'h00);
		look(6'h21, 3'h6, lmc_pkg::LMC_DRV_GROUND);
		$display("t_stall done");
	endtask : t_stall
	task t_pd;
		st(8'h18, 6'h20, 3'h7, lmc_pkg::LMC_DRV_GROUND);
		st(8'h56, 6'h30, 3'h6, lmc_pkg::LMC_DRV_GROUND);
		idle(1000);
		chk(8'(ticks), 8'h00);
		st(8'h1a, 6'h32, 3'h2, lmc_pkg::LMC_DRV_GROUND);
		chk(8'(pin_out), 8'h01);
		st(8'h57, 6'h3a, 3'h2, lmc_pkg::LMC_DRV_GROUND);
		$display("t_pd done");
	endtask : t_pd
	task wrap_up;
		$display("fails=%0d comparisons=%0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 arst_n = 1'b1;
		t_mode();
		t_clk();
		t_frame();
		t_stall();
		t_pd();
		wrap_up();
	end
	// about 0.6 ms of traffic expected
	initial begin
		#2000000;
		fails++;
		wrap_up();
	end
endmodule : tb
